/* File: core/scfg_params.svh */
// Functional notes
// (RQ1) Driver format 0 is high impedance, 1 LVPECL, 2 LVDS, 3 HCSL; it resets to 1.
// (RQ2) Output control bit 7 powers the output buffer down, resets to 0 and is not image-loaded.
// (RQ3) The 9-bit output divide ratio is upper divider bit 0 as bit 8 over the lower byte.
// (RQ4) The ratio equals the value for 5 to 511; the host must not program reserved 0 to 4.
// (RQ5) The lower output divider byte resets to 0x20 and the upper register to zero, ratio 32.
// (RQ6) The 12-bit loop integer divider is upper register bits 3 to 0 over the lower byte.
// (RQ7) The lower loop integer byte resets to 0x32 and the upper four divider bits to zero.
// (RQ8) The 22-bit numerator is top register bits 5 to 0, then the middle and bottom bytes.
// (RQ9) The 22-bit denominator is assembled from its three registers the same way.
// (RQ10) Every defined bit of the numerator and denominator registers resets to zero.
// (RQ11) The 10-bit crystal trim keeps bits 1 to 0 in the first register, 9 to 2 in the second.
// (RQ12) The trim register with the eight upper bits resets to 0x80, the other two bits to zero.
// (RQ13) Image-backed fields take the stored image when it is loaded; others keep their values. Power-down keeps its value and takes host writes in a load.
// (RQ14) Reserved bits with undefined reset read zero and ignore writes; the host writes zero.
`ifndef SCFG_PARAMS_SVH
`define SCFG_PARAMS_SVH

`define SCFG_ADDR_TRIM_HI 8'h10
`define SCFG_ADDR_TRIM_LO 8'h11
`define SCFG_ADDR_OUT_CTL 8'h15
`define SCFG_ADDR_ODIV_HI 8'h16
`define SCFG_ADDR_ODIV_LO 8'h17
`define SCFG_ADDR_NDIV_HI 8'h19
`define SCFG_ADDR_NDIV_LO 8'h1a
`define SCFG_ADDR_NUM_TOP 8'h1b
`define SCFG_ADDR_NUM_MID 8'h1c
`define SCFG_ADDR_NUM_BOT 8'h1d
`define SCFG_ADDR_DEN_TOP 8'h1e
`define SCFG_ADDR_DEN_MID 8'h1f
`define SCFG_ADDR_DEN_BOT 8'h20

`define SCFG_BIT_PWRDN 7
`define SCFG_RST_TRIM_HI 2'h0
`define SCFG_RST_TRIM_LO 8'h80
`define SCFG_RST_PWRDN 1'h0
`define SCFG_RST_OUT_SEL 2'h1
`define SCFG_RST_ODIV_RSVD 7'h00
`define SCFG_RST_ODIV_HI 1'h0
`define SCFG_RST_ODIV_LO 8'h20
`define SCFG_RST_NDIV_HI 4'h0
`define SCFG_RST_NDIV_LO 8'h32
`define SCFG_RST_FRAC_TOP 6'h00
`define SCFG_RST_FRAC_BYTE 8'h00
`define SCFG_ODIV_MIN 9'h005

`endif

/* File: core/scfg_pkg.sv */
package scfg_pkg;

    typedef enum logic [1:0] {
        SCFG_FMT_HIZ = 2'h0,
        SCFG_FMT_LVPECL = 2'h1,
        SCFG_FMT_LVDS = 2'h2,
        SCFG_FMT_HCSL = 2'h3
    } scfg_format_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scfg_req_s;

    typedef struct packed {
        logic [9:0] trim;
        logic [1:0] outSel;
        logic [6:0] outDivRsvd;
        logic [8:0] outDiv;
        logic [11:0] loopInt;
        logic [21:0] fracNum;
        logic [21:0] fracDen;
    } scfg_image_s;

    typedef struct packed {
        logic [9:0] crystalTrimOffset;
        logic outputBufferPowerdown;
        scfg_format_e driverFormat;
        logic [8:0] outDivRatio;
        logic [11:0] loopIntegerDivider;
        logic [21:0] loopFractionNumerator;
        logic [21:0] loopFractionDenominator;
    } scfg_cfg_s;

endpackage : scfg_pkg

/* File: core/scfg_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scfg_params.svh"

module scfg_regs (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire scfg_pkg::scfg_req_s regReq,
    output logic [7:0] regRdata,
    output logic regRvalid,
    input wire logic nvmLoad,
    input wire scfg_pkg::scfg_image_s nvmImage,
    output scfg_pkg::scfg_cfg_s cfg,
    output logic outputHiZ,
    output logic outDivReserved
);
    import scfg_pkg::*;

    logic [1:0] trimHi_q;
    logic [7:0] trimLo_q;
    logic pwrdn_q;
    logic [1:0] outSel_q;
    logic [6:0] odivRsvd_q;
    logic odivHi_q;
    logic [7:0] odivLo_q;
    logic [3:0] ndivHi_q;
    logic [7:0] ndivLo_q;
    logic [5:0] numTop_q;
    logic [7:0] numMid_q;
    logic [7:0] numBot_q;
    logic [5:0] denTop_q;
    logic [7:0] denMid_q;
    logic [7:0] denBot_q;
    logic [7:0] rdata_d;
    logic [7:0] regRdata_q;
    logic regRvalid_q;
    logic outputHiZ_q;
    logic outDivReserved_q;

    function automatic logic wrHit(input scfg_req_s req, input logic [7:0] offs);
        wrHit = req.wr && (req.addr == offs);
    endfunction : wrHit

    // Crystal trim
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            trimHi_q <= `SCFG_RST_TRIM_HI; // [RQ12]
            trimLo_q <= `SCFG_RST_TRIM_LO; // [RQ12]
        end else if (nvmLoad) begin
            trimHi_q <= nvmImage.trim[1:0]; // [RQ13] [RQ11]
            trimLo_q <= nvmImage.trim[9:2]; // [RQ13] [RQ11]
        end else begin
            if (wrHit(regReq, `SCFG_ADDR_TRIM_HI)) begin
                trimHi_q <= regReq.wdata[1:0]; // [RQ11] [RQ14]
            end
            if (wrHit(regReq, `SCFG_ADDR_TRIM_LO)) begin
                trimLo_q <= regReq.wdata; // [RQ11]
            end
        end
    end

    // Output control: power-down has no stored default
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pwrdn_q <= `SCFG_RST_PWRDN; // [RQ2]
            outSel_q <= `SCFG_RST_OUT_SEL; // [RQ1]
        end else begin
            if (nvmLoad) begin
                outSel_q <= nvmImage.outSel; // [RQ13]
            end else if (wrHit(regReq, `SCFG_ADDR_OUT_CTL)) begin
                outSel_q <= regReq.wdata[1:0]; // [RQ1] [RQ14]
            end
            if (wrHit(regReq, `SCFG_ADDR_OUT_CTL)) begin
                pwrdn_q <= regReq.wdata[`SCFG_BIT_PWRDN]; // [RQ2]
            end
        end
    end

    // Output divider
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            odivRsvd_q <= `SCFG_RST_ODIV_RSVD; // [RQ5]
            odivHi_q <= `SCFG_RST_ODIV_HI; // [RQ5]
            odivLo_q <= `SCFG_RST_ODIV_LO; // [RQ5]
        end else if (nvmLoad) begin
            odivRsvd_q <= nvmImage.outDivRsvd; // [RQ13]
            odivHi_q <= nvmImage.outDiv[8]; // [RQ13]
            odivLo_q <= nvmImage.outDiv[7:0]; // [RQ13]
        end else begin
            if (wrHit(regReq, `SCFG_ADDR_ODIV_HI)) begin
                odivRsvd_q <= regReq.wdata[7:1];
                odivHi_q <= regReq.wdata[0]; // [RQ3]
            end
            if (wrHit(regReq, `SCFG_ADDR_ODIV_LO)) begin
                odivLo_q <= regReq.wdata; // [RQ3]
            end
        end
    end

    // Loop integer divider
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ndivHi_q <= `SCFG_RST_NDIV_HI; // [RQ7]
            ndivLo_q <= `SCFG_RST_NDIV_LO; // [RQ7]
        end else if (nvmLoad) begin
            ndivHi_q <= nvmImage.loopInt[11:8]; // [RQ13]
            ndivLo_q <= nvmImage.loopInt[7:0]; // [RQ13]
        end else begin
            if (wrHit(regReq, `SCFG_ADDR_NDIV_HI)) begin
                ndivHi_q <= regReq.wdata[3:0]; // [RQ6] [RQ14]
            end
            if (wrHit(regReq, `SCFG_ADDR_NDIV_LO)) begin
                ndivLo_q <= regReq.wdata; // [RQ6]
            end
        end
    end

    // Fractional numerator
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            numTop_q <= `SCFG_RST_FRAC_TOP; // [RQ10]
            numMid_q <= `SCFG_RST_FRAC_BYTE; // [RQ10]
            numBot_q <= `SCFG_RST_FRAC_BYTE; // [RQ10]
        end else if (nvmLoad) begin
            numTop_q <= nvmImage.fracNum[21:16]; // [RQ13]
            numMid_q <= nvmImage.fracNum[15:8]; // [RQ13]
            numBot_q <= nvmImage.fracNum[7:0]; // [RQ13]
        end else begin
            if (wrHit(regReq, `SCFG_ADDR_NUM_TOP)) begin
                numTop_q <= regReq.wdata[5:0]; // [RQ8] [RQ14]
            end
            if (wrHit(regReq, `SCFG_ADDR_NUM_MID)) begin
                numMid_q <= regReq.wdata; // [RQ8]
            end
            if (wrHit(regReq, `SCFG_ADDR_NUM_BOT)) begin
                numBot_q <= regReq.wdata; // [RQ8]
            end
        end
    end

    // Fractional denominator
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            denTop_q <= `SCFG_RST_FRAC_TOP; // [RQ10]
            denMid_q <= `SCFG_RST_FRAC_BYTE; // [RQ10]
            denBot_q <= `SCFG_RST_FRAC_BYTE; // [RQ10]
        end else if (nvmLoad) begin
            denTop_q <= nvmImage.fracDen[21:16]; // [RQ13]
            denMid_q <= nvmImage.fracDen[15:8]; // [RQ13]
            denBot_q <= nvmImage.fracDen[7:0]; // [RQ13]
        end else begin
            if (wrHit(regReq, `SCFG_ADDR_DEN_TOP)) begin
                denTop_q <= regReq.wdata[5:0]; // [RQ9] [RQ14]
            end
            if (wrHit(regReq, `SCFG_ADDR_DEN_MID)) begin
                denMid_q <= regReq.wdata; // [RQ9]
            end
            if (wrHit(regReq, `SCFG_ADDR_DEN_BOT)) begin
                denBot_q <= regReq.wdata; // [RQ9]
            end
        end
    end

    // Read-back; unmapped addresses return zero
    always_comb begin
        rdata_d = 8'h00;
        case (regReq.addr)
            `SCFG_ADDR_TRIM_HI: rdata_d = {6'h00, trimHi_q}; // [RQ14]
            `SCFG_ADDR_TRIM_LO: rdata_d = trimLo_q;
            `SCFG_ADDR_OUT_CTL: rdata_d = {pwrdn_q, 5'h00, outSel_q}; // [RQ14]
            `SCFG_ADDR_ODIV_HI: rdata_d = {odivRsvd_q, odivHi_q};
            `SCFG_ADDR_ODIV_LO: rdata_d = odivLo_q;
            `SCFG_ADDR_NDIV_HI: rdata_d = {4'h0, ndivHi_q}; // [RQ14]
            `SCFG_ADDR_NDIV_LO: rdata_d = ndivLo_q;
            `SCFG_ADDR_NUM_TOP: rdata_d = {2'h0, numTop_q}; // [RQ14]
            `SCFG_ADDR_NUM_MID: rdata_d = numMid_q;
            `SCFG_ADDR_NUM_BOT: rdata_d = numBot_q;
            `SCFG_ADDR_DEN_TOP: rdata_d = {2'h0, denTop_q}; // [RQ14]
            `SCFG_ADDR_DEN_MID: rdata_d = denMid_q;
            `SCFG_ADDR_DEN_BOT: rdata_d = denBot_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata_q <= 8'h00;
            regRvalid_q <= 1'h0;
        end else begin
            regRvalid_q <= regReq.rd;
            if (regReq.rd) begin
                regRdata_q <= rdata_d;
            end
        end
    end

    // Decoded status flags, one cycle behind the fields
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            outputHiZ_q <= 1'h0;
            outDivReserved_q <= 1'h0;
        end else begin
            outputHiZ_q <= (outSel_q == SCFG_FMT_HIZ); // [RQ1]
            outDivReserved_q <= ({odivHi_q, odivLo_q} < `SCFG_ODIV_MIN); // [RQ4]
        end
    end

    assign regRdata = regRdata_q;
    assign regRvalid = regRvalid_q;
    assign outputHiZ = outputHiZ_q;
    assign outDivReserved = outDivReserved_q;
    // One driver for the whole output struct
    assign cfg = '{
        crystalTrimOffset: {trimLo_q, trimHi_q}, // [RQ11]
        outputBufferPowerdown: pwrdn_q, // [RQ2]
        driverFormat: scfg_format_e'(outSel_q), // [RQ1]
        outDivRatio: {odivHi_q, odivLo_q}, // [RQ3] [RQ4]
        loopIntegerDivider: {ndivHi_q, ndivLo_q}, // [RQ6]
        loopFractionNumerator: {numTop_q, numMid_q, numBot_q}, // [RQ8]
        loopFractionDenominator: {denTop_q, denMid_q, denBot_q} // [RQ9]
    };

endmodule : scfg_regs
`default_nettype wire

/* File: bench/scfg_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module scfg_regs_chk (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire scfg_pkg::scfg_req_s regReq,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid,
    input wire logic nvmLoad,
    input wire scfg_pkg::scfg_image_s nvmImage,
    input wire scfg_pkg::scfg_cfg_s cfg,
    input wire logic outputHiZ,
    input wire logic outDivReserved
);
    import scfg_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Host write that is not overridden by an image load
    wire logic hostWr = regReq.wr && !nvmLoad;
    property p_hiz; 1 |=> outputHiZ == ($past(cfg.driverFormat) == SCFG_FMT_HIZ); endproperty
    a_hiz: assert property (p_hiz) else $error("high impedance flag wrong");
    property p_odres; 1 |=> outDivReserved == ($past(cfg.outDivRatio) < 9'h005); endproperty
    a_odres: assert property (p_odres) else $error("divider reserved flag wrong");
    property p_odlo;
        hostWr && regReq.addr == 8'h17 |=> cfg.outDivRatio[7:0] == $past(regReq.wdata);
    endproperty
    a_odlo: assert property (p_odlo) else $error("divider low byte wrong");
    property p_odhi;
        hostWr && regReq.addr == 8'h16 |=> cfg.outDivRatio[8] == $past(regReq.wdata[0]);
    endproperty
    a_odhi: assert property (p_odhi) else $error("divider bit 8 wrong");
    property p_ndhi;
        hostWr && regReq.addr == 8'h19
            |=> cfg.loopIntegerDivider[11:8] == $past(regReq.wdata[3:0]);
    endproperty
    a_ndhi: assert property (p_ndhi) else $error("loop divider top wrong");
    property p_numtop;
        hostWr && regReq.addr == 8'h1b
            |=> cfg.loopFractionNumerator[21:16] == $past(regReq.wdata[5:0]);
    endproperty
    a_numtop: assert property (p_numtop) else $error("numerator top wrong");
    property p_dentop;
        hostWr && regReq.addr == 8'h1e
            |=> cfg.loopFractionDenominator[21:16] == $past(regReq.wdata[5:0]);
    endproperty
    a_dentop: assert property (p_dentop) else $error("denominator top wrong");
    property p_pdwr;
        regReq.wr && regReq.addr == 8'h15 |=> cfg.outputBufferPowerdown == $past(regReq.wdata[7]);
    endproperty
    a_pdwr: assert property (p_pdwr) else $error("power down bit wrong");
    property p_nvm; nvmLoad |=> cfg.loopIntegerDivider == $past(nvmImage.loopInt); endproperty
    a_nvm: assert property (p_nvm) else $error("image load missed");
    property p_rsvd;
        regReq.rd && regReq.addr == 8'h19 |=> regRvalid && regRdata[7:4] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    c_load: cover property (nvmLoad && regReq.wr);
    c_res: cover property ($rose(outDivReserved));
    c_hiz: cover property ($rose(outputHiZ));
endmodule : scfg_regs_chk
bind scfg_regs scfg_regs_chk u_chk (.clk_sys, .sys_rst, .regReq, .regRdata, .regRvalid,
    .nvmLoad, .nvmImage, .cfg, .outputHiZ, .outDivReserved);
`default_nettype wire

/* File: bench/scfg_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scfg_host (
    input wire logic clk_sys,
    output var scfg_pkg::scfg_req_s regReq,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid
);
    import scfg_pkg::*;
    initial regReq = '0;
    // Released lines show inverted values so stale data is never mistaken for valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regReq = '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(negedge clk_sys);
        regReq = '{addr: ~a, wdata: ~d, wr: 1'h0, rd: 1'h0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        regReq = '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(negedge clk_sys);
        regReq = '{addr: ~a, wdata: 8'hff, wr: 1'h0, rd: 1'h0};
        d = regRvalid ? regRdata : 8'hxx;
    endtask : rd
endmodule : scfg_host
`default_nettype wire

/* File: bench/synth_divider_config_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module synth_divider_config_regs_tb;
    import scfg_pkg::*;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic nvmLoad = 1'h0;
    scfg_image_s nvmImage = '0;
    scfg_req_s regReq;
    logic [7:0] regRdata;
    logic regRvalid;
    scfg_cfg_s cfg;
    logic outputHiZ;
    logic outDivReserved;
    int nMismatch = 0;
    int checks = 0;
    logic [7:0] rb;
    // Address, written byte, reset value, readback after write
    logic [31:0] tbl [14] = '{32'h10a60002, 32'h115c805c, 32'h15820182, 32'h16010001,
        32'h17ff20ff, 32'h197a000a, 32'h1a3c323c, 32'h1be50025, 32'h1c120012,
        32'h1d340034, 32'h1ec70007, 32'h1f560056, 32'h20780078, 32'h12ff0000};
    logic [8:0] dv [3] = '{9'h004, 9'h005, 9'h100};
    scfg_cfg_s rstCfg = '{10'h200, 1'h0, SCFG_FMT_LVPECL, 9'h020, 12'h032, 22'h0, 22'h0};
    scfg_regs u_scfg_regs (.clk_sys, .sys_rst, .regReq, .regRdata, .regRvalid, .nvmLoad,
        .nvmImage, .cfg, .outputHiZ, .outDivReserved);
    scfg_host u_scfg_host (.clk_sys, .regReq, .regRdata, .regRvalid);
    always #5 clk_sys = ~clk_sys;
    task automatic cmpByte(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            nMismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmpByte
    task automatic cmpCfg(input scfg_cfg_s g, input scfg_cfg_s e);
        checks++;
        if (g !== e) begin
            nMismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmpCfg
    task automatic printVerdict;
        if (nMismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : printVerdict
    initial begin
        repeat (20000) @(posedge clk_sys);
        nMismatch++;
        printVerdict();
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'h0;
        cmpCfg(cfg, rstCfg);
        foreach (tbl[i]) begin
            u_scfg_host.rd(tbl[i][31:24], rb);
            cmpByte(rb, tbl[i][15:8]);
        end
        foreach (tbl[i]) begin
            u_scfg_host.wr(tbl[i][31:24], tbl[i][23:16]);
        end
        foreach (tbl[i]) begin
            u_scfg_host.rd(tbl[i][31:24], rb);
            cmpByte(rb, tbl[i][7:0]);
        end
        cmpCfg(cfg, '{10'h172, 1'h1, SCFG_FMT_LVDS, 9'h1ff, 12'ha3c, 22'h251234,
            22'h075678});
        for (int f = 0; f < 4; f++) begin
            u_scfg_host.wr(8'h15, 8'(f));
            @(negedge clk_sys);
            cmpByte({6'h00, cfg.driverFormat}, 8'(f));
            cmpByte({7'h00, outputHiZ}, {7'h00, f == 0});
        end
        foreach (dv[i]) begin
            u_scfg_host.wr(8'h16, {7'h00, dv[i][8]});
            u_scfg_host.wr(8'h17, dv[i][7:0]);
            @(negedge clk_sys);
            cmpByte(cfg.outDivRatio[7:0], dv[i][7:0]);
            cmpByte({cfg.outDivRatio[8], 6'h00, outDivReserved},
                {dv[i][8], 6'h00, dv[i] < 9'h005});
        end
        nvmImage = '{10'h2c1, 2'h0, 7'h00, 9'h0c3, 12'h5a7, 22'h3abcde, 22'h012345};
        fork
            u_scfg_host.wr(8'h15, 8'h80);
            begin
                @(negedge clk_sys);
                nvmLoad = 1'h1;
                @(negedge clk_sys);
                nvmLoad = 1'h0;
            end
        join
        @(negedge clk_sys);
        cmpCfg(cfg, '{10'h2c1, 1'h1, SCFG_FMT_HIZ, 9'h0c3, 12'h5a7, 22'h3abcde,
            22'h012345});
        cmpByte({7'h00, outputHiZ}, 8'h01);
        sys_rst = 1'h1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'h0;
        cmpCfg(cfg, rstCfg);
        u_scfg_host.rd(8'h15, rb);
        cmpByte(rb, 8'h01);
        printVerdict();
    end
endmodule : synth_divider_config_regs_tb
`default_nettype wire
